// ---- core/cluster_event_select_snapshot_regs.sv ----
/*
 * Event selection and counter-zero snapshot register bank, AXI4-Lite
 * slave. Filter and event fields drive the counter logic outside.
 * Assumes lock, power and permission levels arrive asynchronously from
 * other logic and that capture data is stable while its strobe is high.
 */
`timescale 1ns/1ps
module cluster_event_select_snapshot_regs #(
  parameter int IMPL_COUNTERS = 6
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire evsel_pkg::axil_req_t   axi_req_in,
  output evsel_pkg::axil_rsp_t        axi_rsp_out,
  input  wire evsel_pkg::access_state_t access_in,
  input  wire logic                   capture_strobe_in,
  input  wire logic [63:0]            counter_zero_in,
  output logic [3:0]                  secure_count_en_out,
  output logic [3:0]                  nonsecure_count_en_out,
  output logic [3:0][15:0]            event_number_out
);
  import evsel_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_DONE = 3'b100
  } bus_state_t;

  typedef struct packed {
    access_state_t sync1;
    access_state_t sync2;
    bus_state_t    wr_state;
    logic [11:0]   awaddr;
    logic          aw_held;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          w_held;
    logic [1:0]    bresp;
    bus_state_t    rd_state;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          rd_from_store;
    logic [63:0]   capture;
    logic          capture_lo_sel;
    logic [3:0]    sec_en;
    logic [3:0]    nsec_en;
    logic [3:0][15:0] evnum;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  logic [31:0]      store_rd;
  logic [3:0][31:0] store_all;
  logic             store_we;
  logic [1:0]       store_widx;
  logic [1:0]       store_ridx;
  logic [31:0]      store_wdata;

  // ************************************************************
  // helpers
  // ************************************************************
  // decodes a selection offset; valid only for the stored slots
  function automatic logic sel_hit(input logic [11:0] a,
                                   output logic [1:0] idx);
    logic hit;
    hit = 1'b0;
    idx = 2'b00;
    if (a == EVSEL_2_OFFSET) begin
      hit = 1'b1;
      idx = 2'd0;
    end else if (a == EVSEL_3_OFFSET) begin
      hit = 1'b1;
      idx = 2'd1;
    end else if (a == EVSEL_4_OFFSET) begin
      hit = 1'b1;
      idx = 2'd2;
    end else if (a == EVSEL_5_OFFSET) begin
      hit = 1'b1;
      idx = 2'd3;
    end
    return hit;
  endfunction

  // any selection slot, counters 0 to 30, implemented or not
  function automatic logic sel_space(input logic [11:0] a);
    return (a >= EVSEL_BASE_OFFSET) &&
           (a <= EVSEL_BASE_OFFSET + 12'(4 * MAX_COUNTER_INDEX)) &&
           (a[1:0] == 2'b00);
  endfunction

  function automatic logic access_ok(input access_state_t s);
    return s.core_power_on && !s.double_lock_engaged &&
           !s.os_lock_engaged && s.external_monitor_permit;
  endfunction

  function automatic logic slot_implemented(input logic [1:0] idx);
    return (int'(idx) + FIRST_SEL_INDEX) < IMPL_COUNTERS;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic        hit;
    logic [1:0]  idx;
    logic        ok;
    logic        wr_go;
    logic        rd_go;
    hit         = 1'b0;
    idx         = 2'b00;
    ok          = 1'b0;
    wr_go       = 1'b0;
    rd_go       = 1'b0;
    state_next  = state_reg;
    store_we    = 1'b0;
    store_widx  = 2'b00;
    store_wdata = 32'h0000_0000;
    store_ridx  = 2'b00;

    state_next.sync1 = access_in;
    state_next.sync2 = state_reg.sync1;
    ok = access_ok(state_reg.sync2);

    if (capture_strobe_in) begin
      state_next.capture = counter_zero_in;
    end

    // ---- write channel ----
    case (state_reg.wr_state)
      ST_IDLE: begin
        if (axi_req_in.awvalid && !state_reg.aw_held) begin
          state_next.awaddr  = axi_req_in.awaddr;
          state_next.aw_held = 1'b1;
        end
        if (axi_req_in.wvalid && !state_reg.w_held) begin
          state_next.wdata  = axi_req_in.wdata;
          state_next.wstrb  = axi_req_in.wstrb;
          state_next.w_held = 1'b1;
        end
        wr_go = state_reg.aw_held && state_reg.w_held;
        if (wr_go) begin
          hit = sel_hit(state_reg.awaddr, idx);
          state_next.wr_state = ST_RESP;
          state_next.aw_held  = 1'b0;
          state_next.w_held   = 1'b0;
          if (!ok) begin
            state_next.bresp = RESP_SLVERR;
          end else if (state_reg.sync2.sw_lock_engaged) begin
            state_next.bresp = RESP_SLVERR;
          end else if (hit) begin
            state_next.bresp = RESP_OKAY;
            store_we    = slot_implemented(idx);
            store_widx  = idx;
            store_wdata = state_reg.wdata & SEL_WRITE_MASK;
          end else if (sel_space(state_reg.awaddr)) begin
            state_next.bresp = RESP_OKAY;
          end else if (state_reg.awaddr == CAPTURE_LO_OFFSET ||
                       state_reg.awaddr == CAPTURE_HI_OFFSET) begin
            state_next.bresp = RESP_SLVERR;
          end else begin
            state_next.bresp = RESP_DECERR;
          end
        end
      end
      ST_RESP: begin
        if (axi_req_in.bready) begin
          state_next.wr_state = ST_IDLE;
        end
      end
      default: begin
        state_next.wr_state = ST_IDLE;
      end
    endcase

    // ---- read channel ----
    case (state_reg.rd_state)
      ST_IDLE: begin
        rd_go = axi_req_in.arvalid;
        if (rd_go) begin
          hit = sel_hit(axi_req_in.araddr, idx);
          store_ridx = idx;
          state_next.rd_from_store = 1'b0;
          state_next.rdata = 32'h0000_0000;
          state_next.rresp = RESP_OKAY;
          state_next.rd_state = ST_DONE;
          if (!ok) begin
            state_next.rresp = RESP_SLVERR;
          end else if (hit) begin
            state_next.rd_from_store = slot_implemented(idx);
          end else if (sel_space(axi_req_in.araddr)) begin
            state_next.rdata = 32'h0000_0000;
          end else if (axi_req_in.araddr == CAPTURE_LO_OFFSET) begin
            state_next.rdata = state_reg.capture[31:0];
          end else if (axi_req_in.araddr == CAPTURE_HI_OFFSET) begin
            state_next.rdata = state_reg.capture[63:32];
          end else begin
            state_next.rresp = RESP_DECERR;
          end
        end
      end
      ST_DONE: begin
        // store read data lands this cycle
        if (state_reg.rd_from_store) begin
          state_next.rdata = store_rd;
        end
        state_next.rd_from_store = 1'b0;
        state_next.rd_state = ST_RESP;
      end
      ST_RESP: begin
        if (axi_req_in.rready) begin
          state_next.rd_state = ST_IDLE;
        end
      end
      default: begin
        state_next.rd_state = ST_IDLE;
      end
    endcase

    // ---- counter controls ----
    for (int i = 0; i < SEL_COUNT; i++) begin
      state_next.sec_en[i] = !store_all[i][SECURE_FILTER_BIT];
      state_next.nsec_en[i] = store_all[i][NONSECURE_FILTER_BIT] ==
                              store_all[i][SECURE_FILTER_BIT];
      state_next.evnum[i] = store_all[i][EVENT_NUMBER_MSB:0];
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // fixed reset for unknown fields
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg          <= '0;
      state_reg.wr_state <= ST_IDLE;
      state_reg.rd_state <= ST_IDLE;
      state_reg.capture  <= CAPTURE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  evsel_store #(
    .DEPTH (SEL_COUNT),
    .AW    (SEL_INDEX_WIDTH)
  ) u_store (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (store_we),
    .wr_idx_in   (store_widx),
    .wr_data_in  (store_wdata),
    .wr_strb_in  (state_reg.wstrb),
    .rd_idx_in   (store_ridx),
    .rd_data_out (store_rd),
    .all_out     (store_all)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    axi_rsp_out         = '0;
    axi_rsp_out.awready = (state_reg.wr_state == ST_IDLE) &&
                          !state_reg.aw_held;
    axi_rsp_out.wready  = (state_reg.wr_state == ST_IDLE) &&
                          !state_reg.w_held;
    axi_rsp_out.bvalid  = state_reg.wr_state == ST_RESP;
    axi_rsp_out.bresp   = state_reg.bresp;
    axi_rsp_out.arready = state_reg.rd_state == ST_IDLE;
    axi_rsp_out.rvalid  = state_reg.rd_state == ST_RESP;
    axi_rsp_out.rdata   = state_reg.rdata;
    axi_rsp_out.rresp   = state_reg.rresp;
  end

  assign secure_count_en_out    = state_reg.sec_en;
  assign nonsecure_count_en_out = state_reg.nsec_en;
  assign event_number_out       = state_reg.evnum;

endmodule // cluster_event_select_snapshot_regs

// ---- core/evsel_pkg.sv ----
/*
 * Package for the event selection and snapshot register bank: offsets,
 * field layout, reset values and the packed carriers.
 * Assumes nothing of its surroundings.
 */
package evsel_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] EVSEL_BASE_OFFSET  = 12'h400;
  localparam logic [11:0] EVSEL_2_OFFSET     = 12'h408;
  localparam logic [11:0] EVSEL_3_OFFSET     = 12'h40c;
  localparam logic [11:0] EVSEL_4_OFFSET     = 12'h410;
  localparam logic [11:0] EVSEL_5_OFFSET     = 12'h414;
  localparam logic [11:0] CAPTURE_LO_OFFSET  = 12'h600;
  localparam logic [11:0] CAPTURE_HI_OFFSET  = 12'h604;
  localparam logic [11:0] LOCK_CTRL_OFFSET   = 12'h700;
  localparam logic [11:0] CAPTURE_CTRL_OFFSET = 12'h704;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int SECURE_FILTER_BIT    = 31;
  localparam int NONSECURE_FILTER_BIT = 29;
  localparam int EVENT_NUMBER_MSB     = 15;
  localparam int EVENT_NUMBER_WIDTH   = 16;
  localparam int FIRST_SEL_INDEX      = 2;
  localparam int SEL_COUNT            = 4;
  localparam int MAX_COUNTER_INDEX    = 30;
  localparam int SEL_INDEX_WIDTH      = 2;
  localparam logic [31:0] SEL_WRITE_MASK = 32'ha000_ffff;

  // ************************************************************
  // reset values (any value is legal here, zero chosen)
  // ************************************************************
  localparam logic [31:0] SEL_RESET      = 32'h0000_0000;
  localparam logic [63:0] CAPTURE_RESET  = 64'h0000_0000_0000_0000;

  // ************************************************************
  // axi responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

  typedef struct packed {
    logic core_power_on;
    logic double_lock_engaged;
    logic os_lock_engaged;
    logic external_monitor_permit;
    logic sw_lock_engaged;
  } access_state_t;

  typedef struct packed {
    logic                          secure_filter;
    logic                          nonsecure_filter;
    logic [EVENT_NUMBER_WIDTH-1:0] event_number;
  } event_select_t;

endpackage

// ---- core/evsel_store.sv ----
/*
 * Small register store for the event selection words, one per counter
 * from index 2 up; read data come from a register.
 * Assumes the caller masks write data and decides write permission.
 */
`timescale 1ns/1ps
module evsel_store #(
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic          clk_in,
  input  wire logic          reset_n_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_idx_in,
  input  wire logic [31:0]   wr_data_in,
  input  wire logic [3:0]    wr_strb_in,
  input  wire logic [AW-1:0] rd_idx_in,
  output logic      [31:0]   rd_data_out,
  output logic [DEPTH-1:0][31:0] all_out
);
  import evsel_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0]            rd;
  } store_state_t;

  store_state_t state_reg;
  store_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_en_in) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb_in[b]) begin
          state_next.mem[wr_idx_in][b*8 +: 8] = wr_data_in[b*8 +: 8];
        end
      end
    end
    state_next.rd = state_reg.mem[rd_idx_in];
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out = state_reg.rd;
  assign all_out     = state_reg.mem;

endmodule // evsel_store

// ---- dv/axil_host_model.sv ----
/* Debugger-side AXI4-Lite master with a settable answer stall.
   Assumes the slave answers every request in time. */
`timescale 1ns/1ps
module axil_host_model (
  input  wire logic                 clk_in,
  output evsel_pkg::axil_req_t      req_out,
  input  wire evsel_pkg::axil_rsp_t rsp_in
);
  import evsel_pkg::*;
  int stall = 0;
  initial req_out = '0;
  // released addresses and write data are inverted so stale values cannot pass
  task automatic answer(input logic is_rd);
    repeat (stall) @(posedge clk_in);
    if (is_rd) req_out.rready <= 1'b1;
    else req_out.bready <= 1'b1;
    do @(posedge clk_in);
    while (!(is_rd ? rsp_in.rvalid : rsp_in.bvalid));
    req_out.rready <= 1'b0;
    req_out.bready <= 1'b0;
  endtask
  task automatic write(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_in);
    req_out.awaddr <= a;
    req_out.awvalid <= 1'b1;
    req_out.wdata <= d;
    req_out.wstrb <= s;
    req_out.wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_in);
      if (!aw_done && rsp_in.awready) begin
        aw_done = 1'b1;
        req_out.awvalid <= 1'b0;
        req_out.awaddr <= ~a;
      end
      if (!w_done && rsp_in.wready) begin
        w_done = 1'b1;
        req_out.wvalid <= 1'b0;
        req_out.wdata <= ~d;
      end
    end
    answer(1'b0);
  endtask
  task automatic read(input logic [11:0] a);
    @(posedge clk_in);
    req_out.araddr <= a;
    req_out.arvalid <= 1'b1;
    do @(posedge clk_in);
    while (!rsp_in.arready);
    req_out.arvalid <= 1'b0;
    req_out.araddr <= ~a;
    answer(1'b1);
  endtask
endmodule // axil_host_model

// ---- dv/evsel_checker.sv ----
/* Port checker for the selection and snapshot bank.
   Assumes the bank's ports and the evsel_pkg layout. */
`timescale 1ns/1ps
module evsel_checker #(
  parameter int IMPL_COUNTERS = 6
) (
  input wire logic                     clk_in,
  input wire logic                     reset_n_in,
  input wire evsel_pkg::axil_req_t     axi_req_in,
  input wire evsel_pkg::axil_rsp_t     axi_rsp_out,
  input wire evsel_pkg::access_state_t access_in,
  input wire logic                     capture_strobe_in,
  input wire logic [63:0]              counter_zero_in,
  input wire logic [3:0]               secure_count_en_out,
  input wire logic [3:0]               nonsecure_count_en_out,
  input wire logic [3:0][15:0]         event_number_out
);
  import evsel_pkg::*;
  logic [11:0] rd_addr_reg;
  logic [11:0] wr_addr_reg;
  logic [4:0]  acc_prev_reg;
  logic [2:0]  stable_reg;
  logic [63:0] cap_reg;
  logic [4:0]  slot;
  logic [1:0]  j;
  logic        sel_hit;
  logic        impl_hit;
  logic        snap_hit;
  logic        acc_ok;
  logic        rd_ok;
  assign slot = rd_addr_reg[6:2];
  assign j = slot[1:0] - 2'h2;
  assign sel_hit = rd_addr_reg[11:7] == 5'h08 && rd_addr_reg[1:0] == 2'h0;
  assign impl_hit = sel_hit && slot >= 5'h02 && slot <= 5'h05
                    && slot < IMPL_COUNTERS;
  assign snap_hit = rd_addr_reg[11:3] == 9'h0c0;
  assign acc_ok = access_in.core_power_on && !access_in.double_lock_engaged
                  && !access_in.os_lock_engaged
                  && access_in.external_monitor_permit;
  assign rd_ok = axi_rsp_out.rvalid && axi_rsp_out.rresp == RESP_OKAY;
  // stable_reg: access levels need time to pass the synchroniser
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_addr_reg <= 12'h000;
      wr_addr_reg <= 12'h000;
      acc_prev_reg <= 5'h00;
      stable_reg <= 3'h0;
      cap_reg <= CAPTURE_RESET;
    end else begin
      if (axi_req_in.arvalid && axi_rsp_out.arready)
        rd_addr_reg <= axi_req_in.araddr;
      if (axi_req_in.awvalid && axi_rsp_out.awready)
        wr_addr_reg <= axi_req_in.awaddr;
      acc_prev_reg <= access_in;
      if (access_in != acc_prev_reg) stable_reg <= 3'h0;
      else if (stable_reg != 3'h7) stable_reg <= stable_reg + 3'h1;
      if (capture_strobe_in) cap_reg <= counter_zero_in;
    end
  end
  // ****************************
  // assertions
  // ****************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  rsv_bits_a: assert property (
    rd_ok && sel_hit |-> (axi_rsp_out.rdata & ~SEL_WRITE_MASK) == 32'h0)
    else $error("reserved selection bits not zero");
  secure_en_a: assert property (
    rd_ok && impl_hit |-> secure_count_en_out[j] == !axi_rsp_out.rdata[31])
    else $error("secure enable disagrees with filter bit");
  nonsec_en_a: assert property (
    rd_ok && impl_hit |-> nonsecure_count_en_out[j]
      == (axi_rsp_out.rdata[29] == axi_rsp_out.rdata[31]))
    else $error("nonsecure enable disagrees with filter bits");
  event_num_a: assert property (
    rd_ok && impl_hit |-> event_number_out[j] == axi_rsp_out.rdata[15:0])
    else $error("event number output differs");
  absent_zero_a: assert property (
    rd_ok && sel_hit && !impl_hit |-> axi_rsp_out.rdata == 32'h0)
    else $error("absent slot reads nonzero");
  snap_value_a: assert property (
    rd_ok && snap_hit |-> axi_rsp_out.rdata
      == (rd_addr_reg[2] ? cap_reg[63:32] : cap_reg[31:0]))
    else $error("snapshot word differs");
  snap_ro_a: assert property (
    $rose(axi_rsp_out.bvalid) && wr_addr_reg[11:3] == 9'h0c0
    |-> axi_rsp_out.bresp != RESP_OKAY)
    else $error("snapshot write accepted");
  denied_read_a: assert property (
    $rose(axi_rsp_out.rvalid) && stable_reg >= 3'h4 && !acc_ok
    && (sel_hit || snap_hit) |-> axi_rsp_out.rresp == RESP_SLVERR)
    else $error("denied read not refused");
  locked_write_a: assert property (
    $rose(axi_rsp_out.bvalid) && stable_reg >= 3'h4 && acc_ok
    && access_in.sw_lock_engaged |-> axi_rsp_out.bresp != RESP_OKAY)
    else $error("locked write accepted");
  read_answer_a: assert property (
    axi_req_in.arvalid && axi_rsp_out.arready |-> ##2 axi_rsp_out.rvalid)
    else $error("read answer late");
  resp_hold_a: assert property (
    axi_rsp_out.bvalid && !axi_req_in.bready
    |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
    else $error("write response dropped early");
  cover property (rd_ok && impl_hit);
  cover property ($rose(axi_rsp_out.bvalid) && !acc_ok);
  cover property (capture_strobe_in);
endmodule // evsel_checker

bind cluster_event_select_snapshot_regs evsel_checker #(
  .IMPL_COUNTERS(IMPL_COUNTERS)
) chk_inst (
  .clk_in                 (clk_in),
  .reset_n_in             (reset_n_in),
  .axi_req_in             (axi_req_in),
  .axi_rsp_out            (axi_rsp_out),
  .access_in              (access_in),
  .capture_strobe_in      (capture_strobe_in),
  .counter_zero_in        (counter_zero_in),
  .secure_count_en_out    (secure_count_en_out),
  .nonsecure_count_en_out (nonsecure_count_en_out),
  .event_number_out       (event_number_out)
);

// ---- dv/tb_cluster_event_select_snapshot_regs.sv ----
/* Bench for the selection and snapshot bank: host model drives it,
   answers are checked against a queue of notes.
   Assumes the package constants and the bank's bus latencies. */
`timescale 1ns/1ps
`define check_eq(got, want) begin checks_done++; if ((got) !== (want)) \
  begin n_mismatch++; $display("Error %0t: got %h want %h", $time, \
  got, want); end end
module tb_cluster_event_select_snapshot_regs;
  import evsel_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } note_t;
  logic          clk_in = 1'b0;
  logic          reset_n_in = 1'b0;
  axil_req_t     req;
  axil_rsp_t     rsp;
  access_state_t access = 5'h12;
  logic          strobe = 1'b0;
  logic [63:0]   count0 = 64'h0;
  logic [31:0]   seed = 32'h82270f04;
  int            n_mismatch = 0;
  int            checks_done = 0;
  int            cycles = 0;
  note_t         rd_notes[$];
  note_t         wr_notes[$];
  note_t         note;
  logic [31:0]   sel_val[4];
  logic [31:0]   d;
  logic [63:0]   snap;
  logic [11:0]   absent[4] = '{12'h400, 12'h404, 12'h418, 12'h478};
  access_state_t bad[4] = '{5'h02, 5'h1a, 5'h16, 5'h10};
  cluster_event_select_snapshot_regs #(.IMPL_COUNTERS(6)) dut (
    .clk_in                 (clk_in),
    .reset_n_in             (reset_n_in),
    .axi_req_in             (req),
    .axi_rsp_out            (rsp),
    .access_in              (access),
    .capture_strobe_in      (strobe),
    .counter_zero_in        (count0),
    .secure_count_en_out    (),
    .nonsecure_count_en_out (),
    .event_number_out       ()
  );
  axil_host_model host (
    .clk_in  (clk_in),
    .req_out (req),
    .rsp_in  (rsp)
  );
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  always @(posedge clk_in) begin
    if (reset_n_in && rsp.rvalid && req.rready) begin
      note = rd_notes.pop_front();
      `check_eq(rsp.rresp, note.resp)
      if (note.resp != RESP_SLVERR) `check_eq(rsp.rdata, note.data)
    end
    if (reset_n_in && rsp.bvalid && req.bready) begin
      note = wr_notes.pop_front();
      `check_eq(rsp.bresp, note.resp)
    end
  end
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    rd_notes.push_back(note_t'{e, r});
    host.read(a);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [3:0] s, input logic [1:0] r);
    wr_notes.push_back(note_t'{32'h0, r});
    host.write(a, v, s);
  endtask
  task automatic settle(input access_state_t s);
    access <= s;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic do_reset();
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) rd(12'(EVSEL_2_OFFSET + 4 * i), SEL_RESET,
                                   RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      host.stall = k % 3;
      d = $random(seed);
      d[15:8] = 8'h00;
      d[31] = k[1];
      d[29] = k[0];
      sel_val[k % 4] = d & SEL_WRITE_MASK;
      wr(12'(EVSEL_2_OFFSET + 4 * (k % 4)), d, 4'hf, RESP_OKAY);
      rd(12'(EVSEL_2_OFFSET + 4 * (k % 4)), sel_val[k % 4],
         RESP_OKAY);
    end
    d = $random(seed);
    wr(EVSEL_3_OFFSET, d, 4'h8, RESP_OKAY);
    sel_val[1] = {d[31], 1'b0, d[29], sel_val[1][28:0]};
    rd(EVSEL_3_OFFSET, sel_val[1], RESP_OKAY);
    foreach (absent[i]) begin
      wr(absent[i], 32'hffff_ffff, 4'hf, RESP_OKAY);
      rd(absent[i], 32'h0, RESP_OKAY);
    end
    snap = {$random(seed), $random(seed)};
    count0 <= snap;
    strobe <= 1'b1;
    @(posedge clk_in);
    strobe <= 1'b0;
    rd(CAPTURE_LO_OFFSET, snap[31:0], RESP_OKAY);
    wr(CAPTURE_LO_OFFSET, 32'h0, 4'hf, RESP_SLVERR);
    rd(CAPTURE_HI_OFFSET, snap[63:32], RESP_OKAY);
    settle(5'h13);
    wr(EVSEL_4_OFFSET, 32'h0000_0011, 4'hf, RESP_SLVERR);
    rd(EVSEL_4_OFFSET, sel_val[2], RESP_OKAY);
    foreach (bad[i]) begin
      settle(bad[i]);
      rd(EVSEL_2_OFFSET, 32'h0, RESP_SLVERR);
      wr(EVSEL_2_OFFSET, 32'h0, 4'hf, RESP_SLVERR);
    end
    settle(5'h12);
    rd(EVSEL_2_OFFSET, sel_val[0], RESP_OKAY);
    rd(LOCK_CTRL_OFFSET, 32'h0, RESP_DECERR);
    wr(LOCK_CTRL_OFFSET, 32'h1, 4'hf, RESP_DECERR);
    do_reset();
    rd(EVSEL_5_OFFSET, SEL_RESET, RESP_OKAY);
    repeat (4) @(posedge clk_in);
    tally_and_finish();
  end
endmodule // tb_cluster_event_select_snapshot_regs
